// >>> src/bdtnd_defines.vh
// register offsets, field positions, reset values and timing figures of the baud timer block
// assumes inclusion by bare name from the top design file under src/ and from the files under tb/
`ifndef BDTND_DEFINES_VH
`define BDTND_DEFINES_VH

// register byte offsets
`define BDTND_OFF_CTRL 8'h00
`define BDTND_OFF_RELOAD 8'h04
`define BDTND_OFF_COUNT 8'h08
`define BDTND_OFF_TMR1 8'h0C
`define BDTND_OFF_STAT 8'h10
`define BDTND_OFF_CLR 8'h14
`define BDTND_OFF_IEN 8'h18
`define BDTND_OFF_PRE 8'h1C

// control register fields
`define BDTND_CTRL_EN 0
`define BDTND_CTRL_NDM 1
`define BDTND_CTRL_DBL 2
`define BDTND_CTRL_T1RUN 3
`define BDTND_CTRL_SMODE_LO 4
`define BDTND_CTRL_SMODE_HI 5
`define BDTND_CTRL_OVF 6

// status and enable fields
`define BDTND_ST_NDOVF 0
`define BDTND_ST_T1OVF 1
`define BDTND_ST_W 2

// reset values
`define BDTND_RST_CTRL 8'h00
`define BDTND_RST_RELOAD 8'h00
`define BDTND_RST_TMR1 8'h00
`define BDTND_RST_PRE 8'h00

// the fixed baud divide: 32 x 2 timer 1 overflows per bit at single rate
`define BDTND_BAUD_DIV 7'h40
`define BDTND_SER_MODE1 2'h1
`define BDTND_SER_MODE3 2'h3

// AXI responses
`define BDTND_RESP_OKAY 2'h0
`define BDTND_RESP_SLVERR 2'h2

`endif

// >>> src/bdtnd_reload_counter.v
// WIDTH-bit up counter, 8 by default, that reloads on overflow and flags each wrap
// assumes step is a one-cycle enable from the same clock as aclk
module bdtnd_reload_counter #(
    parameter WIDTH = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire run,
    input wire step,
    input wire [WIDTH-1:0] reload,
    output reg [WIDTH-1:0] count_r,
    output reg wrap_r
);

    wire at_top;
    assign at_top = &count_r;

    // reload in the same step as the wrap, so a period is exactly 2^W - reload steps
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= {WIDTH{1'b0}};
            wrap_r <= 1'b0;
        end else begin
            wrap_r <= 1'b0;
            if (!run) begin
                count_r <= reload; // idle counter sits at reload so it starts from it
            end else if (step) begin
                if (at_top) begin
                    count_r <= reload;
                    wrap_r <= 1'b1;
                end else begin
                    count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule

// >>> src/bdtnd_top.v
// baud timer and normal divider with an AXI4-Lite register slave
// assumes one clock aclk, synchronous active-low aresetn, single-beat AXI4-Lite master
module bdtnd_top #(
    parameter CW = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg baud_tick_r,
    output reg divided_output_clock_r,
    output reg irq_r
);

`include "bdtnd_defines.vh"

    // software state, prescale and baud counters, AXI write capture
    reg [7:0] divider_control_reg;
    reg [7:0] divider_reload_reg;
    reg [7:0] timer1_high_reload_byte;
    reg [7:0] prescale_r;
    reg [`BDTND_ST_W-1:0] stat_r;
    reg [`BDTND_ST_W-1:0] ien_r;
    reg [7:0] pre_cnt_r;
    reg [6:0] baud_cnt_r;
    reg [7:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;

    wire [7:0] divider_count_reg;
    wire t1_wrap;
    wire nd_wrap;
    wire [7:0] t1_count;

    // named control fields
    wire divider_enable_bit;
    wire normal_divider_select;
    wire double_rate_select;
    wire t1_run;
    wire [1:0] ser_mode;
    assign divider_enable_bit = divider_control_reg[`BDTND_CTRL_EN];
    assign normal_divider_select = divider_control_reg[`BDTND_CTRL_NDM];
    assign double_rate_select = divider_control_reg[`BDTND_CTRL_DBL];
    assign t1_run = divider_control_reg[`BDTND_CTRL_T1RUN];
    assign ser_mode = divider_control_reg[`BDTND_CTRL_SMODE_HI:`BDTND_CTRL_SMODE_LO];

    // divider input clock: one-cycle enable from a programmable prescaler
    wire div_step;
    assign div_step = (pre_cnt_r == prescale_r);

    always @(posedge aclk) begin
        if (!aresetn) begin
            pre_cnt_r <= 8'h00;
        end else if (div_step) begin
            pre_cnt_r <= 8'h00;
        end else begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
        end
    end

    // timer 1 in 8-bit auto-reload, counting peripheral clocks; reload byte sets the rate
    bdtnd_reload_counter #(
        .WIDTH(8)
    ) u_timer1 (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(t1_run),
        .step(1'b1),
        .reload(timer1_high_reload_byte),
        .count_r(t1_count),
        .wrap_r(t1_wrap)
    );

    // normal divider: runs only when selected and enabled
    bdtnd_reload_counter #(
        .WIDTH(CW)
    ) u_divider (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(normal_divider_select & divider_enable_bit),
        .step(div_step),
        .reload(divider_reload_reg),
        .count_r(divider_count_reg),
        .wrap_r(nd_wrap)
    );

    // serial modes with a variable rate
    wire var_mode;
    assign var_mode = (ser_mode == `BDTND_SER_MODE1) || (ser_mode == `BDTND_SER_MODE3);

    // bit tick every 64 overflows, or every 32 at double rate; 2^double_rate_select folded into the limit
    wire [6:0] baud_lim;
    assign baud_lim = double_rate_select ? (`BDTND_BAUD_DIV >> 1) : `BDTND_BAUD_DIV;

    always @(posedge aclk) begin
        if (!aresetn) begin
            baud_cnt_r <= 7'h00;
            baud_tick_r <= 1'b0;
        end else begin
            baud_tick_r <= 1'b0;
            if (!var_mode || normal_divider_select) begin
                baud_cnt_r <= 7'h00;
            end else if (t1_wrap) begin
                if (baud_cnt_r == baud_lim - 7'h01) begin
                    baud_cnt_r <= 7'h00;
                    baud_tick_r <= 1'b1;
                end else begin
                    baud_cnt_r <= baud_cnt_r + 7'h01;
                end
            end
        end
    end

    // output clock is one pulse per wrap, so its rate is the step rate over n
    // a toggle would halve the rate; the trade is a narrow high phase
    always @(posedge aclk) begin
        if (!aresetn) begin
            divided_output_clock_r <= 1'b0;
        end else if (!(normal_divider_select & divider_enable_bit)) begin
            divided_output_clock_r <= 1'b0;
        end else begin
            divided_output_clock_r <= nd_wrap;
        end
    end

    // AXI write path: address and data taken in either order
    wire aw_take;
    wire w_take;
    wire wr_go;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;

    function [7:0] lane_merge;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            lane_merge = strb[0] ? data[7:0] : old;
        end
    endfunction

    wire wr_ctrl;
    wire wr_clr;
    assign wr_ctrl = wr_go && (aw_addr_r == `BDTND_OFF_CTRL);
    assign wr_clr = wr_go && (aw_addr_r == `BDTND_OFF_CLR) && w_strb_r[0];

    function addr_ok;
        input [7:0] a;
        begin
            addr_ok = (a[1:0] == 2'b00) && (a <= `BDTND_OFF_PRE);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `BDTND_RESP_OKAY;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_ok(aw_addr_r) ? `BDTND_RESP_OKAY : `BDTND_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // register writes; the count and status are read-only
    always @(posedge aclk) begin
        if (!aresetn) begin
            divider_control_reg <= `BDTND_RST_CTRL;
            divider_reload_reg <= `BDTND_RST_RELOAD;
            timer1_high_reload_byte <= `BDTND_RST_TMR1;
            prescale_r <= `BDTND_RST_PRE;
            ien_r <= {`BDTND_ST_W{1'b0}};
        end else if (wr_go) begin
            case (aw_addr_r)
                `BDTND_OFF_CTRL: begin
                    divider_control_reg <= lane_merge(divider_control_reg, w_data_r, w_strb_r);
                end
                `BDTND_OFF_RELOAD: begin
                    divider_reload_reg <= lane_merge(divider_reload_reg, w_data_r, w_strb_r);
                end
                `BDTND_OFF_TMR1: begin
                    timer1_high_reload_byte <=
                        lane_merge(timer1_high_reload_byte, w_data_r, w_strb_r);
                end
                `BDTND_OFF_PRE: begin
                    prescale_r <= lane_merge(prescale_r, w_data_r, w_strb_r);
                end
                `BDTND_OFF_IEN: begin
                    if (w_strb_r[0]) begin
                        ien_r <= w_data_r[`BDTND_ST_W-1:0];
                    end
                end
                default: begin
                    ien_r <= ien_r;
                end
            endcase
        end
    end

    // sticky status; a new event beats a clear in the same cycle
    wire [`BDTND_ST_W-1:0] ev;
    wire [`BDTND_ST_W-1:0] clr_mask;
    assign ev = {t1_wrap & t1_run, nd_wrap};
    assign clr_mask = wr_clr ? w_data_r[`BDTND_ST_W-1:0] : {`BDTND_ST_W{1'b0}};

    // overflow flag also readable in the control register, write 1 to clear there too
    wire ovf_wclr;
    assign ovf_wclr = wr_ctrl && w_strb_r[0] && w_data_r[`BDTND_CTRL_OVF];

    always @(posedge aclk) begin
        if (!aresetn) begin
            stat_r <= {`BDTND_ST_W{1'b0}};
            irq_r <= 1'b0;
        end else begin
            stat_r <= ev | (stat_r & ~clr_mask &
                ~{{(`BDTND_ST_W-1){1'b0}}, ovf_wclr});
            irq_r <= |((ev | (stat_r & ~clr_mask)) & ien_r);
        end
    end

    // read path: one cycle after the address is taken
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `BDTND_OFF_CTRL: begin
                rd_mux[7:0] = divider_control_reg;
                rd_mux[`BDTND_CTRL_OVF] = stat_r[`BDTND_ST_NDOVF];
            end
            `BDTND_OFF_RELOAD: rd_mux[7:0] = divider_reload_reg;
            `BDTND_OFF_COUNT: rd_mux[7:0] = divider_count_reg;
            `BDTND_OFF_TMR1: rd_mux[15:0] = {t1_count, timer1_high_reload_byte};
            `BDTND_OFF_STAT: rd_mux[`BDTND_ST_W-1:0] = stat_r;
            `BDTND_OFF_IEN: rd_mux[`BDTND_ST_W-1:0] = ien_r;
            `BDTND_OFF_PRE: rd_mux[7:0] = prescale_r;
            default: rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `BDTND_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= addr_ok(s_axi_araddr) ? `BDTND_RESP_OKAY : `BDTND_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// >>> tb/bdtnd_bench.sv
// self-checking bench for the baud timer and normal divider
// assumes the block alone on one 50 MHz clock, driven as an AXI4-Lite master
`include "bdtnd_defines.vh"
module bdtnd_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, tick, dclk, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, resp;
    int failures = 0, checks = 0, p, i;
    bdtnd_top i_bdtnd_top (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .baud_tick_r(tick), .divided_output_clock_r(dclk), .irq_r(irq));
    // free-running 20 ns clock
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end
    task cmp(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // address and data offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        bit done;
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'h1; wvalid <= 1'h1; bready <= 1'h1;
        n = 0;
        done = 0;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) begin
                resp = bresp; bready <= 1'h0; done = 1;
            end
        end
        if (!done) cmp(0, 1);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] v);
        int n;
        bit done;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
        n = 0;
        done = 0;
        while (!done && n < 100) begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'h0;
            if (rvalid) begin
                v = rdata; resp = rresp; rready <= 1'h0; done = 1;
            end
        end
        if (!done) cmp(0, 1);
    endtask
    // cycles between the 2nd and 3rd event; 0 when no 3rd event comes in 600 cycles
    task per(input bit div, output int q);
        int n, e, s;
        logic prev;
        n = 0; e = 0; q = 0; s = 0; prev = dclk;
        while (n < 600 && e < 3) begin
            @(posedge aclk);
            n++;
            if (div ? (dclk === 1'h1 && prev === 1'h0) : (tick === 1'h1)) begin
                e++;
                if (e == 2) s = n;
                if (e == 3) q = n - s;
            end
            prev = dclk;
        end
    endtask
    task t_regs;
        logic [7:0] ofs [6] = '{`BDTND_OFF_CTRL, `BDTND_OFF_RELOAD, `BDTND_OFF_COUNT,
            `BDTND_OFF_TMR1, `BDTND_OFF_STAT, `BDTND_OFF_PRE};
        foreach (ofs[k]) begin
            rd(ofs[k], d);
            cmp(d, 0);
        end
        wr(`BDTND_OFF_COUNT, 32'h55);
        rd(`BDTND_OFF_COUNT, d);
        cmp(d, 0);
        rd(8'h20, d);
        cmp(resp, `BDTND_RESP_SLVERR);
        wr(8'h03, 32'h1);
        cmp(resp, `BDTND_RESP_SLVERR);
        $display("test regs done");
    endtask
    task t_div;
        wr(`BDTND_OFF_RELOAD, 32'hFC);
        wr(`BDTND_OFF_IEN, 32'h1);
        wr(`BDTND_OFF_CTRL, 32'h3);
        per(1, p);
        cmp(p, 4);
        wr(`BDTND_OFF_PRE, 32'h1);
        per(1, p);
        cmp(p, 8);
        per(0, p);
        cmp(p, 0);
        cmp(irq, 1);
        wr(`BDTND_OFF_CTRL, 32'h0);
        rd(`BDTND_OFF_CTRL, d);
        cmp(d[6], 1);
        rd(`BDTND_OFF_STAT, d);
        cmp(d[0], 1);
        rd(`BDTND_OFF_COUNT, d);
        cmp(d, 32'hFC);
        // masking must drop the line while status stays set
        wr(`BDTND_OFF_IEN, 32'h0);
        repeat (2) @(posedge aclk);
        cmp(irq, 0);
        wr(`BDTND_OFF_IEN, 32'h1);
        repeat (2) @(posedge aclk);
        cmp(irq, 1);
        wr(`BDTND_OFF_CLR, 32'h1);
        rd(`BDTND_OFF_STAT, d);
        cmp(d[0], 0);
        cmp(irq, 0);
        $display("test divider done");
    endtask
    task t_baud;
        logic [31:0] ctl [6] = '{32'h18, 32'h1C, 32'h38, 32'h08, 32'h28, 32'h1A};
        int exp [6] = '{128, 64, 128, 0, 0, 0};
        wr(`BDTND_OFF_TMR1, 32'hFE);
        for (i = 0; i < 6; i++) begin
            wr(`BDTND_OFF_CTRL, ctl[i]);
            per(0, p);
            cmp(p, exp[i]);
        end
        $display("test baud done");
    endtask
    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // inputs known at time zero, reset for six cycles
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs;
        t_div;
        t_baud;
        summarize;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        summarize;
    end
endmodule

// >>> tb/bdtnd_top_asserts.sv
// concurrent checks on the baud timer block, watching only its top ports
// assumes one clock aclk and a synchronous active-low aresetn
`include "bdtnd_defines.vh"
module bdtnd_top_asserts #(
    parameter CW = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic baud_tick_r,
    input wire logic divided_output_clock_r,
    input wire logic irq_r
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // answers must stand until taken, or the master loses them
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_R_NEXT: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid)
        else $error("read answer late");
    // both halves taken at one edge: held a cycle, answered the cycle after
    AST_B_NEXT: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    AST_W_BLOCK: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    AST_W_FREE: assert property (s_axi_bvalid && s_axi_bready
        |=> s_axi_awready && s_axi_wready)
        else $error("write not reopened");
    AST_R_BAD: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > 8'h1C |=> s_axi_rresp == `BDTND_RESP_SLVERR)
        else $error("unmapped read not refused");
    AST_CLR_ZERO: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == `BDTND_OFF_CLR |=> s_axi_rdata == 32'h0)
        else $error("clear reads nonzero");
    AST_TICK_GAP: assert property (baud_tick_r
        |=> !baud_tick_r [*8])
        else $error("bit ticks too close");
    COV_TICK: cover property (baud_tick_r);
    COV_DCLK: cover property ($rose(divided_output_clock_r));
    COV_IRQ: cover property ($rose(irq_r));
endmodule

bind bdtnd_top bdtnd_top_asserts #(.CW(CW)) i_bdtnd_top_asserts (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .baud_tick_r, .divided_output_clock_r, .irq_r);
